// file: logic/rts_pkg.sv
// Package of constants and types for the radio telegram scheduler.
package rts_pkg;

  // ***********************************************************************
  // Timing constants
  // ***********************************************************************
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned EDIT_HOLD_MS    = 2000;
  localparam int unsigned EDIT_MAX_MS     = 3000;
  localparam int unsigned HOLD_TICK_MS    = 10;
  localparam int unsigned HOLD_TICK_CYC   = (CLK_HZ / 1000) * HOLD_TICK_MS;
  localparam int unsigned EDIT_HOLD_TICKS = EDIT_HOLD_MS / HOLD_TICK_MS;
  localparam int unsigned EDIT_MAX_TICKS  = EDIT_MAX_MS / HOLD_TICK_MS;
  localparam int unsigned INSTALL_MIN     = 60;
  localparam int unsigned INSTALL_SEC     = INSTALL_MIN * 60;
  localparam int unsigned INSTALL_IVL_SEC = 36;
  localparam int unsigned IVL_MIN_SEC     = 10;
  localparam int unsigned IVL_MAX_MIN     = 240;
  localparam int unsigned IVL_MAX_SEC     = IVL_MAX_MIN * 60;
  localparam int unsigned DAY_MINUTES     = 1440;
  localparam int unsigned TZ_OFFSET_MIN   = 60;

  // ***********************************************************************
  // Display positions, reset values and telegram type codes
  // ***********************************************************************
  localparam logic [3:0] MODULE_LOOP      = 4'h6;
  localparam logic [3:0] RADIO_ENTRY      = 4'h2;
  localparam logic [3:0] CRYPT_ENTRY      = 4'h3;
  localparam logic       RADIO_EN_RST     = 1'b0;
  localparam logic       CRYPT_EN_RST     = 1'b0;
  localparam logic [7:0] TG_FMT_DESC      = 8'h01;
  localparam logic [7:0] TG_COMPACT       = 8'h02;
  localparam logic [7:0] TG_SHORT         = 8'h03;
  localparam logic [7:0] TG_LONG          = 8'h04;

  // Radio link modes.
  typedef enum logic [1:0] {
    RTS_MODE_S1 = 2'b00,
    RTS_MODE_T1 = 2'b01,
    RTS_MODE_C1 = 2'b10
  } rts_mode_e;

  // Button state machine.
  typedef enum logic [1:0] {
    RTS_BTN_IDLE = 2'b00,
    RTS_BTN_HOLD = 2'b01,
    RTS_BTN_PEN  = 2'b10,
    RTS_BTN_DONE = 2'b11
  } rts_btn_e;

endpackage : rts_pkg

// file: logic/rts_fifo.sv
// Parameterised synchronous FIFO for outgoing telegram descriptors.
`timescale 1ns/100ps
`default_nettype none
module rts_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_valid_in,
  output var  logic             wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output var  logic             rd_valid_out,
  input  wire logic             rd_ready_in,
  output var  logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  // Full and empty come from pointer comparison with a wrap bit.
  assign full         = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  assign empty        = (wptr_r == rptr_r);
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem_r[rptr_r[AW-1:0]];
  assign do_wr        = wr_valid_in && !full;
  assign do_rd        = rd_ready_in && !empty;

  // Storage write.
  always_ff @(posedge core_clk_in)
  begin
    if (do_wr)
    begin
      mem_r[wptr_r[AW-1:0]] <= wr_data_in;
    end
  end

  // Pointer update.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (do_rd)
      begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end
endmodule : rts_fifo
`default_nettype wire

// file: logic/rts_scheduler.sv
// Radio telegram scheduler: activation, installation mode and transmit timing.
`timescale 1ns/100ps
`default_nettype none
module rts_scheduler
  import rts_pkg::*;
#(
  parameter int unsigned HOLD_TICK_CYCLES = HOLD_TICK_CYC,
  parameter int          FIFO_DEPTH       = 32
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        button_in,
  input  wire logic [3:0]  disp_loop_in,
  input  wire logic [3:0]  disp_entry_in,
  input  wire logic        sec_tick_in,
  input  wire logic [10:0] utc_minute_in,
  input  wire logic [2:0]  weekday_in,
  input  wire logic [2:0]  week_of_month_in,
  input  wire logic [3:0]  month_in,
  input  wire logic [4:0]  day_in,
  input  wire logic        cfg_write_in,
  input  wire logic        cfg_radio_en_in,
  input  wire logic        cfg_crypt_en_in,
  input  wire logic [13:0] cfg_interval_sec_in,
  input  wire logic [10:0] cfg_win_start_in,
  input  wire logic [10:0] cfg_win_end_in,
  input  wire logic [6:0]  cfg_weekday_mask_in,
  input  wire logic [2:0]  cfg_weeks_in,
  input  wire logic [11:0] cfg_month_mask_in,
  input  wire logic [4:0]  cfg_act_day_in,
  input  wire logic [3:0]  cfg_act_month_in,
  input  wire logic [1:0]  cfg_mode_in,
  input  wire logic        cfg_sec_mode7_in,
  input  wire logic        cfg_inst_key_in,
  input  wire logic        cfg_long_tg_in,
  input  wire logic        cfg_semimonthly_in,
  input  wire logic        cfg_compact_in,
  input  wire logic        tx_ready_in,
  output logic             tx_valid_out,
  output logic [15:0]      tx_desc_out,
  output logic             radio_enabled_entry_out,
  output logic             crypt_enabled_out,
  output logic             edit_pen_out,
  output logic             triangle_out,
  output logic             install_mode_out,
  output logic             frame_b_out,
  output logic [10:0]      local_minute_out
);

  // ***********************************************************************
  // Input synchroniser and helpers
  // ***********************************************************************
  logic          btn_meta_r;
  logic          btn_sync_r;
  logic          btn_prev_r;
  rts_btn_e      btn_state_r;
  logic [8:0]    hold_ticks_r;
  logic [23:0]   tick_cnt_r;
  logic          tick_pulse;
  logic          radio_en_r;
  logic          crypt_en_r;
  logic          pen_r;
  logic          target_crypt_r;
  logic          commit_radio;
  logic          commit_crypt;
  logic [11:0]   inst_left_r;
  logic [5:0]    inst_ivl_r;
  logic [13:0]   norm_ivl_r;
  logic          fmt_next_r;
  logic          send_req;
  logic          sched_ok;
  logic [13:0]   eff_ivl;
  logic [15:0]   tg_desc;
  logic          fifo_wr_ready;
  logic          fifo_rd_valid;
  logic [15:0]   fifo_rd_data;
  logic [10:0]   local_min;
  logic [10:0]   local_min_r;

  // Adds the fixed standard-time offset and wraps within the day.
  function automatic logic [10:0] add_tz(input logic [10:0] m);
    logic [11:0] s;
    s = {1'b0, m} + 12'(TZ_OFFSET_MIN);
    if (s >= 12'(DAY_MINUTES))
    begin
      s = s - 12'(DAY_MINUTES);
    end
    return s[10:0];
  endfunction : add_tz

  // True when minute m lies in [start, end); a start above end wraps midnight.
  function automatic logic in_window(input logic [10:0] m, input logic [10:0] st,
                                     input logic [10:0] en);
    if (st <= en)
    begin
      return (m >= st) && (m < en);
    end
    return (m >= st) || (m < en);
  endfunction : in_window

  // The button is a pin, so it passes two flops before any logic uses it.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      btn_meta_r <= 1'b0;
      btn_sync_r <= 1'b0;
      btn_prev_r <= 1'b0;
    end
    else
    begin
      btn_meta_r <= button_in;
      btn_sync_r <= btn_meta_r;
      btn_prev_r <= btn_sync_r;
    end
  end

  // Hold timing runs on a 10 ms tick to keep the hold counter narrow.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || (btn_sync_r && !btn_prev_r) || tick_pulse)
    begin
      tick_cnt_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick_pulse = (tick_cnt_r == 24'(HOLD_TICK_CYCLES - 1));

  // ***********************************************************************
  // Button edit sequence
  // ***********************************************************************
  // Short releases fall back to idle with no change; holds past 3 s abort.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      btn_state_r    <= RTS_BTN_IDLE;
      hold_ticks_r   <= '0;
      pen_r          <= 1'b0;
      target_crypt_r <= 1'b0;
    end
    else
    begin
      case (btn_state_r)
        RTS_BTN_IDLE:
        begin
          hold_ticks_r <= '0;
          pen_r        <= 1'b0;
          if (btn_sync_r && !btn_prev_r && disp_loop_in == MODULE_LOOP)
          begin
            // Only the "off" entries open an edit; disabling is not offered.
            if (disp_entry_in == RADIO_ENTRY && !radio_en_r)
            begin
              btn_state_r    <= RTS_BTN_HOLD;
              target_crypt_r <= 1'b0;
            end
            else if (disp_entry_in == CRYPT_ENTRY && !crypt_en_r)
            begin
              btn_state_r    <= RTS_BTN_HOLD;
              target_crypt_r <= 1'b1;
            end
          end
        end
        RTS_BTN_HOLD:
        begin
          if (!btn_sync_r)
          begin
            btn_state_r <= RTS_BTN_IDLE;
          end
          else if (tick_pulse)
          begin
            hold_ticks_r <= hold_ticks_r + 1'b1;
            if (hold_ticks_r == 9'(EDIT_HOLD_TICKS - 1))
            begin
              btn_state_r <= RTS_BTN_PEN;
              pen_r       <= 1'b1;
            end
          end
        end
        RTS_BTN_PEN:
        begin
          if (!btn_sync_r)
          begin
            btn_state_r <= RTS_BTN_IDLE;
            pen_r       <= 1'b0;
          end
          else if (tick_pulse)
          begin
            hold_ticks_r <= hold_ticks_r + 1'b1;
            if (hold_ticks_r == 9'(EDIT_MAX_TICKS - 1))
            begin
              btn_state_r <= RTS_BTN_DONE;
              pen_r       <= 1'b0;
            end
          end
        end
        RTS_BTN_DONE:
        begin
          // Held too long: wait for release without committing.
          if (!btn_sync_r)
          begin
            btn_state_r <= RTS_BTN_IDLE;
          end
        end
        default:
        begin
          btn_state_r <= RTS_BTN_IDLE;
        end
      endcase
    end
  end

  // Release while the pen is shown commits the pending edit.
  assign commit_radio = (btn_state_r == RTS_BTN_PEN) && !btn_sync_r && !target_crypt_r;
  assign commit_crypt = (btn_state_r == RTS_BTN_PEN) && !btn_sync_r && target_crypt_r;

  // ***********************************************************************
  // Enable flags
  // ***********************************************************************
  // Software may set or clear; the button can only set.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      radio_en_r <= RADIO_EN_RST;
      crypt_en_r <= CRYPT_EN_RST;
    end
    else
    begin
      if (commit_radio)
      begin
        radio_en_r <= 1'b1;
      end
      else if (cfg_write_in)
      begin
        radio_en_r <= cfg_radio_en_in;
      end
      if (commit_crypt)
      begin
        crypt_en_r <= 1'b1;
      end
      else if (cfg_write_in)
      begin
        crypt_en_r <= cfg_crypt_en_in;
      end
    end
  end

  // ***********************************************************************
  // Installation mode and interval timing
  // ***********************************************************************
  // With the radio staying or turning on, any activation or parameter write restarts the 60 minute window.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !(radio_en_r || commit_radio || (cfg_write_in && cfg_radio_en_in)))
    begin
      inst_left_r <= '0;
    end
    else if (commit_radio || commit_crypt || cfg_write_in)
    begin
      inst_left_r <= 12'(INSTALL_SEC);
    end
    else if (sec_tick_in && inst_left_r != '0)
    begin
      inst_left_r <= inst_left_r - 1'b1;
    end
  end

  // Clamp the interval into its legal range.
  assign eff_ivl = (cfg_interval_sec_in < 14'(IVL_MIN_SEC)) ? 14'(IVL_MIN_SEC) :
                   (cfg_interval_sec_in > 14'(IVL_MAX_SEC)) ? 14'(IVL_MAX_SEC) :
                   cfg_interval_sec_in;

  assign local_min = add_tz(utc_minute_in);

  // All calendar conditions must hold together for a regular telegram.
  assign sched_ok = in_window(local_min, cfg_win_start_in, cfg_win_end_in)
                 && cfg_weekday_mask_in[weekday_in]
                 && ((cfg_weeks_in >= 3'd4) || (week_of_month_in < cfg_weeks_in))
                 && cfg_month_mask_in[month_in - 4'd1]
                 && ((month_in > cfg_act_month_in) ||
                     (month_in == cfg_act_month_in && day_in >= cfg_act_day_in));

  // Interval counters; a request fires when a countdown reaches zero.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || !radio_en_r)
    begin
      inst_ivl_r <= '0;
      norm_ivl_r <= '0;
    end
    else if (sec_tick_in)
    begin
      inst_ivl_r <= (inst_ivl_r == '0) ? 6'(INSTALL_IVL_SEC - 1) : inst_ivl_r - 1'b1;
      norm_ivl_r <= (norm_ivl_r == '0) ? eff_ivl - 1'b1 : norm_ivl_r - 1'b1;
    end
  end

  assign send_req = radio_en_r && sec_tick_in && fifo_wr_ready &&
                    ((inst_left_r != '0) ? (inst_ivl_r == '0)
                                         : (norm_ivl_r == '0 && sched_ok));

  // Compact mode alternates format and compact only while installing.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in || inst_left_r == '0)
    begin
      fmt_next_r <= 1'b1;
    end
    else if (send_req)
    begin
      fmt_next_r <= !fmt_next_r;
    end
  end

  // Descriptor: type, security, key, stored-value set, mode and frame.
  always_comb
  begin
    tg_desc = '0;
    if (cfg_compact_in)
    begin
      tg_desc[7:0] = (inst_left_r != '0 && fmt_next_r) ? TG_FMT_DESC : TG_COMPACT;
    end
    else
    begin
      tg_desc[7:0] = cfg_long_tg_in ? TG_LONG : TG_SHORT;
    end
    tg_desc[8]     = cfg_semimonthly_in;
    tg_desc[9]     = crypt_en_r;
    tg_desc[10]    = cfg_sec_mode7_in;
    tg_desc[11]    = cfg_inst_key_in;
    tg_desc[13:12] = cfg_mode_in;
    tg_desc[14]    = (cfg_mode_in == RTS_MODE_C1);
  end

  // ***********************************************************************
  // Outgoing telegram queue
  // ***********************************************************************
  rts_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (send_req),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (tg_desc),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (tx_ready_in && !tx_valid_out),
    .rd_data_out  (fifo_rd_data)
  );

  // Registered output stage; one descriptor held until the radio takes it.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      tx_valid_out <= 1'b0;
      tx_desc_out  <= '0;
    end
    else if (!tx_valid_out && fifo_rd_valid && tx_ready_in)
    begin
      tx_valid_out <= 1'b1;
      tx_desc_out  <= fifo_rd_data;
    end
    else if (tx_valid_out && tx_ready_in)
    begin
      tx_valid_out <= 1'b0;
    end
  end

  // Registered status outputs.
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      radio_enabled_entry_out <= 1'b0;
      crypt_enabled_out       <= 1'b0;
      edit_pen_out            <= 1'b0;
      triangle_out            <= 1'b0;
      install_mode_out        <= 1'b0;
      frame_b_out             <= 1'b0;
      local_min_r             <= '0;
    end
    else
    begin
      radio_enabled_entry_out <= radio_en_r;
      crypt_enabled_out       <= crypt_en_r;
      edit_pen_out            <= pen_r;
      triangle_out            <= radio_en_r;
      install_mode_out        <= (inst_left_r != '0);
      frame_b_out             <= (cfg_mode_in == RTS_MODE_C1);
      local_min_r             <= local_min;
    end
  end
  assign local_minute_out = local_min_r;

endmodule : rts_scheduler
`default_nettype wire

// file: test/rts_scheduler_asserts.sv
// Concurrent checks on the ports of the radio telegram scheduler.
`timescale 1ns/100ps
`default_nettype none
module rts_scheduler_asserts
  import rts_pkg::*;
#(
  parameter int unsigned HOLD_TICK_CYCLES = HOLD_TICK_CYC
) (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        button_in,
  input wire logic [3:0]  disp_loop_in,
  input wire logic        cfg_write_in,
  input wire logic [10:0] utc_minute_in,
  input wire logic        tx_valid_out,
  input wire logic [15:0] tx_desc_out,
  input wire logic        radio_enabled_entry_out,
  input wire logic        crypt_enabled_out,
  input wire logic        edit_pen_out,
  input wire logic        triangle_out,
  input wire logic        install_mode_out,
  input wire logic [10:0] local_minute_out
);
  localparam int unsigned HMIN = (EDIT_HOLD_TICKS - 1) * HOLD_TICK_CYCLES;
  localparam int unsigned HMAX = (EDIT_HOLD_TICKS + 1) * HOLD_TICK_CYCLES + 4;
  logic [31:0] held_r;
  logic [11:0] loc_sum;
  logic [10:0] loc_exp;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Length of the current press; it saturates so a stuck button cannot wrap round.
  always_ff @(posedge core_clk_in)
    if (rst_in || !button_in)
      held_r <= 32'h0;
    else if (held_r != 32'hffffffff)
      held_r <= held_r + 32'h1;
  // Local time is the raw minute moved on by one hour, wrapping at midnight.
  assign loc_sum = {1'b0, utc_minute_in} + 12'h03c;
  assign loc_exp = (loc_sum >= 12'h5a0) ? 11'(loc_sum - 12'h5a0) : loc_sum[10:0];
  property p_reset;
    disable iff (1'b0) rst_in [*2] |-> !tx_valid_out && !radio_enabled_entry_out
      && !install_mode_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared in reset");
  property p_idle;
    !radio_enabled_entry_out [*8] |-> !tx_valid_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("telegram offered while radio off");
  property p_frame;
    tx_valid_out |-> tx_desc_out[14] == (tx_desc_out[13:12] == 2'b10);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame format does not match mode");
  property p_pen_time;
    $rose(edit_pen_out) |-> held_r >= HMIN && held_r <= HMAX;
  endproperty
  a_pen_time: assert property (p_pen_time)
    else $error("edit pen shown at wrong hold time");
  property p_pen_loop;
    $rose(edit_pen_out) |-> disp_loop_in == MODULE_LOOP;
  endproperty
  a_pen_loop: assert property (p_pen_loop)
    else $error("edit pen outside module loop");
  property p_radio_off;
    $fell(radio_enabled_entry_out) |-> $past(cfg_write_in) || $past(cfg_write_in, 2)
      || $past(cfg_write_in, 3);
  endproperty
  a_radio_off: assert property (p_radio_off)
    else $error("radio turned off without configuration");
  property p_crypt_off;
    $fell(crypt_enabled_out) |-> $past(cfg_write_in) || $past(cfg_write_in, 2)
      || $past(cfg_write_in, 3);
  endproperty
  a_crypt_off: assert property (p_crypt_off)
    else $error("encryption turned off without configuration");
  property p_tri;
    radio_enabled_entry_out |-> triangle_out;
  endproperty
  a_tri: assert property (p_tri)
    else $error("triangle missing while radio on");
  property p_install;
    $rose(radio_enabled_entry_out) |-> ##[0:2] install_mode_out;
  endproperty
  a_install: assert property (p_install)
    else $error("installation mode not entered on activation");
  property p_local;
    $stable(utc_minute_in) |=> local_minute_out == $past(loc_exp);
  endproperty
  a_local: assert property (p_local)
    else $error("local minute not one hour ahead");
endmodule : rts_scheduler_asserts
`default_nettype wire

// file: test/rts_sink_model.sv
// Radio sink model that takes telegram descriptors after a random stall.
`timescale 1ns/100ps
`default_nettype none
module rts_sink_model (
  input  wire logic        core_clk_in,
  input  wire logic        stall_in,
  input  wire logic        tx_valid_in,
  input  wire logic [15:0] tx_desc_in,
  output var  logic        tx_ready_out,
  output var  logic        got_out,
  output var  logic [15:0] got_desc_out
);
  int unsigned wait_r = 0;
  initial
  begin
    tx_ready_out = 1'b0;
    got_out = 1'b0;
    got_desc_out = 16'h0;
  end
  // Ready drops after every take, so the source must hold its offer.
  always @(posedge core_clk_in)
  begin
    got_out <= 1'b0;
    if (tx_ready_out && tx_valid_in)
    begin
      got_out <= 1'b1;
      got_desc_out <= tx_desc_in;
      tx_ready_out <= 1'b0;
      wait_r <= $urandom_range(3, 0);
    end
    else if (wait_r != 0)
      wait_r <= wait_r - 1;
    else
      tx_ready_out <= !stall_in;
  end
endmodule : rts_sink_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the radio telegram scheduler.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rts_pkg::*;
  logic core_clk_in = 1'b0, rst_in = 1'b1, button_in = 1'b0, sec_tick_in = 1'b0;
  logic cfg_write_in = 1'b0, stall = 1'b0, sec_en = 1'b1, got, fmt_next = 1'b1;
  logic cfg_radio_en_in = 1'b0, cfg_crypt_en_in = 1'b0, m7 = 1'b0, key = 1'b0;
  logic [3:0] disp_loop_in = 4'h6, disp_entry_in = 4'h1, month_in = 4'h6, amon = 4'h3;
  logic [10:0] utc_minute_in = 11'h578, win_s = 11'h000, win_e = 11'h258;
  logic [2:0] weekday_in = 3'h1, week_of_month_in = 3'h0, weeks = 3'h2;
  logic [4:0] day_in = 5'h0a, aday = 5'h0f;
  logic [6:0] wmask = 7'h77;
  logic [11:0] mmask = 12'hfef;
  logic [13:0] ivl = 14'h000a;
  logic [1:0] mode = 2'h0;
  logic tx_ready_in, tx_valid_out, edit_pen_out, triangle_out, install_mode_out;
  logic radio_enabled_entry_out, crypt_enabled_out, frame_b_out;
  logic [15:0] tx_desc_out, got_desc;
  logic [10:0] local_minute_out;
  int fail_count = 0, total_checks = 0, cyc = 0, secs = 0, t_act = 0, prev = -1;
  int n_got = 0, age = 0, n0 = 0;
  always #25 core_clk_in = !core_clk_in;
  rts_scheduler #(.HOLD_TICK_CYCLES(10), .FIFO_DEPTH(32)) u_rts_scheduler (
    .core_clk_in, .rst_in, .button_in, .disp_loop_in, .disp_entry_in, .sec_tick_in,
    .utc_minute_in, .weekday_in, .week_of_month_in, .month_in, .day_in, .cfg_write_in,
    .cfg_radio_en_in, .cfg_crypt_en_in, .cfg_interval_sec_in(ivl), .cfg_win_start_in(win_s),
    .cfg_win_end_in(win_e), .cfg_weekday_mask_in(wmask), .cfg_weeks_in(weeks),
    .cfg_month_mask_in(mmask), .cfg_act_day_in(aday), .cfg_act_month_in(amon),
    .cfg_mode_in(mode), .cfg_sec_mode7_in(m7), .cfg_inst_key_in(key), .cfg_long_tg_in(1'b1),
    .cfg_semimonthly_in(m7), .cfg_compact_in(1'b1), .tx_ready_in, .tx_valid_out,
    .tx_desc_out, .radio_enabled_entry_out, .crypt_enabled_out, .edit_pen_out,
    .triangle_out, .install_mode_out, .frame_b_out, .local_minute_out);
  rts_sink_model u_rts_sink_model (.core_clk_in, .stall_in(stall), .tx_valid_in(tx_valid_out),
    .tx_desc_in(tx_desc_out), .tx_ready_out(tx_ready_in), .got_out(got), .got_desc_out(got_desc));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  function automatic logic [15:0] exp_desc(input logic [7:0] ty);
    return {1'b0, mode == 2'h2, mode, key, m7, 1'b1, m7, ty};
  endfunction : exp_desc
  task automatic wait_s(input int s);
    repeat (s * 8) @(posedge core_clk_in);
    #1;
  endtask : wait_s
  task automatic press(input logic [3:0] loop, input logic [3:0] entry, input int hold);
    disp_loop_in = loop;
    disp_entry_in = entry;
    button_in = 1'b1;
    repeat (hold) @(posedge core_clk_in);
    #1 button_in = 1'b0;
    repeat (20) @(posedge core_clk_in);
    #1 disp_loop_in = 4'h6;
  endtask : press
  // The operator lets go as soon as the pen appears.
  task automatic long_press(input logic [3:0] entry);
    int n;
    n = 0;
    disp_entry_in = entry;
    button_in = 1'b1;
    while (edit_pen_out !== 1'b1 && n < 2200)
    begin
      @(posedge core_clk_in);
      #1 n = n + 1;
    end
    check("pen_hold", 16'h1, 16'(n >= 1980 && n < 2200));
    button_in = 1'b0;
    repeat (10) @(posedge core_clk_in);
    #1;
  endtask : long_press
  // A second lasts eight clocks so that a whole installation hour fits the run.
  always @(posedge core_clk_in)
  begin
    #1;
    cyc = cyc + 1;
    sec_tick_in = sec_en && (cyc % 8 == 0);
    if (sec_tick_in)
      secs = secs + 1;
  end
  // Every descriptor the sink takes, except within ten seconds of the end of installation, is compared with the expected one.
  always @(posedge core_clk_in)
    if (got === 1'b1)
    begin
      n_got = n_got + 1;
      age = secs - t_act;
      if (age < 3590)
      begin
        check("desc", exp_desc(fmt_next ? TG_FMT_DESC : TG_COMPACT), got_desc);
        fmt_next = !fmt_next;
        if (prev >= 0 && sec_en)
          check("gap", 16'd36, 16'(secs - prev));
      end
      else if (age > 3610)
      begin
        check("desc", exp_desc(TG_COMPACT), got_desc);
        if (prev >= 0 && sec_en)
          check("gap", {2'b00, ivl}, 16'(secs - prev));
      end
      prev = (age < 3590 || age > 3610) ? secs : -1;
    end
  initial
  begin
    void'($urandom(32'hea33de6d));
    mode = 2'($urandom_range(2, 0));
    m7 = 1'($urandom_range(1, 0));
    key = 1'($urandom_range(1, 0));
    ivl = 14'($urandom_range(20, 10));
    repeat (12) @(posedge core_clk_in);
    #1 rst_in = 1'b0;
    check("status", 16'h0, {tx_valid_out, radio_enabled_entry_out, crypt_enabled_out,
      edit_pen_out, triangle_out, install_mode_out});
    cfg_write_in = 1'b1;
    @(posedge core_clk_in);
    #1 cfg_write_in = 1'b0;
    wait_s(40);
    check("frame_b", 16'(mode == 2'h2), frame_b_out);
    check("sent", 16'h0, 16'(n_got));
    press(4'h6, RADIO_ENTRY, 500);
    check("radio", 16'h0, radio_enabled_entry_out);
    press(4'h5, RADIO_ENTRY, 2100);
    check("radio", 16'h0, radio_enabled_entry_out);
    press(4'h6, RADIO_ENTRY, 3400);
    check("radio", 16'h0, radio_enabled_entry_out);
    long_press(CRYPT_ENTRY);
    check("crypt", 16'h1, crypt_enabled_out);
    long_press(RADIO_ENTRY);
    t_act = secs;
    check("radio", 16'h7, {radio_enabled_entry_out, triangle_out, install_mode_out});
    wait_s(3580);
    check("install", 16'h1, install_mode_out);
    check("inst_count", 16'h1, 16'(n_got >= 95));
    wait_s(40);
    check("install", 16'h0, install_mode_out);
    n0 = n_got;
    wait_s(100);
    check("norm_count", 16'h1, 16'(n_got - n0 >= 100 / ivl - 1));
    // Break one calendar condition at a time, then show sending resumes.
    for (int i = 0; i < 5; i++)
    begin
      case (i)
        0: utc_minute_in = 11'h2bc;
        1: weekday_in = 3'h3;
        2: week_of_month_in = 3'h2;
        3: month_in = 4'h5;
        default: month_in = 4'h3;
      endcase
      wait_s(1);
      n0 = n_got;
      wait_s(30);
      check("blocked", 16'(n0), 16'(n_got));
      utc_minute_in = 11'h578;
      weekday_in = 3'h1;
      week_of_month_in = 3'h0;
      month_in = 4'h6;
      prev = -1;
      wait_s(2 * ivl + 2);
      check("resumed", 16'h1, 16'(n_got > n0));
    end
    check("local", 16'h0014, local_minute_out);
    stall = 1'b1;
    wait_s(36 * ivl);
    sec_en = 1'b0;
    n0 = n_got;
    stall = 1'b0;
    repeat (400) @(posedge core_clk_in);
    #1 check("drained", 16'h1, 16'(n_got - n0 == 32 || n_got - n0 == 33));
    prev = -1;
    cfg_crypt_en_in = 1'b0;
    cfg_write_in = 1'b1;
    @(posedge core_clk_in);
    #1 cfg_write_in = 1'b0;
    sec_en = 1'b1;
    n0 = n_got;
    wait_s(30);
    check("off", 16'h0, {radio_enabled_entry_out, crypt_enabled_out, install_mode_out});
    check("sent", 16'(n0), 16'(n_got));
    wrap_up();
  end
  initial
  begin
    repeat (90000) @(posedge core_clk_in);
    fail_count = fail_count + 1;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule : tb_top
bind rts_scheduler rts_scheduler_asserts #(.HOLD_TICK_CYCLES(HOLD_TICK_CYCLES))
  u_rts_scheduler_asserts (.core_clk_in, .rst_in, .button_in, .disp_loop_in, .cfg_write_in,
  .utc_minute_in, .tx_valid_out, .tx_desc_out, .radio_enabled_entry_out, .crypt_enabled_out,
  .edit_pen_out, .triangle_out, .install_mode_out, .local_minute_out);
`default_nettype wire
